// file: hdl/wif_top.sv
// Wake source and interrupt flag registers with their AHB-Lite register access.
// Operation
// - Push-button rising edge sets sticky flag.
// - Sleep or LCD request clears push-button flag.
// - Push-button flag survives wake for boot read.
// - Power rise sets flag, raises power event.
// - Power fall sets flag, raises power event.
// - No loss flag on button/timer brownout wake.
// - Transfer, tick flags follow their interrupts.
// - Hardware sets and clears transfer, tick.
// - Autowake expiry sets autowake flag.
// - Two collision flags, firmware read/write.
// - Level field shows live external inputs.
// - Enables gate watchdog and serial interrupts.
`timescale 1ns/1ps
`include "wif_defines.svh"
module wif_top (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  input wire logic push_button,
  input wire logic clockLockGood,
  input wire logic wakeByButton,
  input wire logic autowakeExpired,
  input wire logic ce_transfer_busy,
  input wire logic one_second_pulse,
  input wire logic collisionEventA,
  input wire logic collisionEventB,
  input wire logic lowPowerRequest,
  input wire logic [6:0] extIrqIn,
  input wire logic watchdogNearOverflow,
  input wire logic serialPortIrq,
  output logic power_event_interrupt,
  output logic watchdogIrq,
  output logic serialIrq
);
  wif_reg_if regs ();
  logic pbSync;
  logic lockSync;
  logic xferSync;
  logic tickSync;
  logic [6:0] extSync;
  logic pbPrev_q;
  logic lockPrev_q;
  logic [7:0] flags_q;
  logic [7:0] flags_d;
  logic [7:0] enable_q;
  logic powerIrq_q;
  logic wdIrq_q;
  logic spiIrq_q;
  logic [7:0] levels;
  wire pbRise;
  wire lockRise;
  wire lockFall;
  wire wrFlags;
  wire wrEnable;
  wire [7:0] setMask;
  wire [7:0] keepMask;
  // =====================================================
  // Input synchronisers
  // =====================================================
  wif_sync u_syncPb (.clock(clock), .rst_n(rst_n), .din(push_button), .dout(pbSync));
  wif_sync u_syncLock (.clock(clock), .rst_n(rst_n), .din(clockLockGood), .dout(lockSync));
  wif_sync u_syncXfer (.clock(clock), .rst_n(rst_n), .din(ce_transfer_busy), .dout(xferSync));
  wif_sync u_syncTick (.clock(clock), .rst_n(rst_n), .din(one_second_pulse), .dout(tickSync));
  genvar gi;
  generate
    for (gi = 0; gi < 7; gi = gi + 1) begin : gExt
      wif_sync u_syncExt (
        .clock(clock),
        .rst_n(rst_n),
        .din(extIrqIn[gi]),
        .dout(extSync[gi])
      );
    end
  endgenerate
  // =====================================================
  // Register bus slave
  // =====================================================
  wif_ahb_slave u_slave (
    .clock(clock),
    .rst_n(rst_n),
    .hsel(hsel),
    .haddr(haddr),
    .htrans(htrans),
    .hwrite(hwrite),
    .hsize(hsize),
    .hwdata(hwdata),
    .hready(hready),
    .rdFlags(flags_q),
    .rdLevels(levels),
    .rdEnable(enable_q),
    .hreadyout(hreadyout),
    .hresp(hresp),
    .hrdata(hrdata),
    .regs(regs.slave)
  );
  // =====================================================
  // Event detection
  // =====================================================
  // Edges are taken from the settled synchroniser outputs.
  assign pbRise = pbSync && !pbPrev_q;
  assign lockRise = lockSync && !lockPrev_q;
  // A fall while the part wakes by button or timer is not a power loss.
  assign lockFall = !lockSync && lockPrev_q && !wakeByButton && !autowakeExpired;
  assign levels = {1'b0, extSync};
  assign wrFlags = regs.wrEn && (regs.wrSel == wif_pkg::WIF_REG_FLAGS);
  assign wrEnable = regs.wrEn && (regs.wrSel == wif_pkg::WIF_REG_ENABLE);
  // Hardware set requests for the sticky and collision flags.
  assign setMask = {lockFall, lockRise, autowakeExpired, pbRise,
                    collisionEventB, collisionEventA, 2'b00};
  // Written zero clears a sticky flag, written one keeps it.
  assign keepMask = wrFlags ? (regs.wrData | ~`WIF_W0C_MASK) : 8'hFF;
  // =====================================================
  // Flag next-state
  // =====================================================
  // Set wins over clear; collision flags also take written values.
  always_comb begin
    flags_d = (flags_q & keepMask) | setMask;
    if (wrFlags) begin
      flags_d[`WIF_BIT_COLA] = regs.wrData[`WIF_BIT_COLA] | collisionEventA;
      flags_d[`WIF_BIT_COLB] = regs.wrData[`WIF_BIT_COLB] | collisionEventB;
    end
    // Low-power request clears the button flag unless a new edge arrives.
    if (lowPowerRequest && !pbRise) begin
      flags_d[`WIF_BIT_PB] = 1'b0;
    end
    flags_d[`WIF_BIT_XFER] = xferSync;
    flags_d[`WIF_BIT_TICK] = tickSync;
  end
  // =====================================================
  // State registers
  // =====================================================
  // Flags clear at device reset, otherwise take the next-state value, and persist through wake.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      pbPrev_q <= 1'b0;
      lockPrev_q <= 1'b0;
      flags_q <= `WIF_RST_BYTE;
    end else begin
      pbPrev_q <= pbSync;
      lockPrev_q <= lockSync;
      flags_q <= flags_d;
    end
  end
  // Enable register holds the two interrupt gates.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      enable_q <= `WIF_RST_BYTE;
    end else if (wrEnable) begin
      enable_q <= regs.wrData & ((8'h01 << `WIF_BIT_WDEN) | (8'h01 << `WIF_BIT_SPIEN));
    end
  end
  // =====================================================
  // Interrupt outputs
  // =====================================================
  // Power event is raised by either power edge.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      powerIrq_q <= 1'b0;
      wdIrq_q <= 1'b0;
      spiIrq_q <= 1'b0;
    end else begin
      powerIrq_q <= lockRise || lockFall;
      wdIrq_q <= watchdogNearOverflow && enable_q[`WIF_BIT_WDEN];
      spiIrq_q <= serialPortIrq && enable_q[`WIF_BIT_SPIEN];
    end
  end
  assign power_event_interrupt = powerIrq_q;
  assign watchdogIrq = wdIrq_q;
  assign serialIrq = spiIrq_q;
endmodule : wif_top

// file: hdl/wif_defines.svh
// Register offsets, field positions and reset values of the wake and interrupt flag block.
`ifndef WIF_DEFINES_SVH
`define WIF_DEFINES_SVH
`define WIF_ADDR_FLAGS 16'h00E8
`define WIF_ADDR_LEVELS 16'h00F8
`define WIF_ADDR_ENABLE 16'h20B0
`define WIF_BIT_XFER 0
`define WIF_BIT_TICK 1
`define WIF_BIT_COLA 2
`define WIF_BIT_COLB 3
`define WIF_BIT_PB 4
`define WIF_BIT_WAKE 5
`define WIF_BIT_PRISE 6
`define WIF_BIT_PFALL 7
`define WIF_BIT_WDEN 0
`define WIF_BIT_SPIEN 4
`define WIF_RST_BYTE 8'h00
`define WIF_W0C_MASK 8'hF0
`endif

// file: hdl/wif_pkg.sv
// Types shared by the wake and interrupt flag block.
package wif_pkg;
  typedef enum logic [1:0] {
    WIF_REG_FLAGS,
    WIF_REG_LEVELS,
    WIF_REG_ENABLE,
    WIF_REG_NONE
  } wif_reg_e;
  typedef logic [7:0] wif_byte_t;
endpackage : wif_pkg

// file: hdl/wif_reg_if.sv
// Register access strobes passed from the bus slave to the flag logic.
`timescale 1ns/1ps
interface wif_reg_if;
  logic wrEn;
  wif_pkg::wif_reg_e wrSel;
  logic [7:0] wrData;
  modport slave (output wrEn, output wrSel, output wrData);
  modport core (input wrEn, input wrSel, input wrData);
endinterface : wif_reg_if

// file: hdl/wif_sync.sv
// Three-stage input synchroniser that reports a value once stages two and three agree.
`timescale 1ns/1ps
module wif_sync (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic din,
  output logic dout
);
  logic s1_q;
  logic s2_q;
  logic s3_q;
  logic out_q;
  // =====================================================
  // Synchroniser chain
  // =====================================================
  // Stage one feeds stage two only; output moves when two and three agree.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      s1_q <= 1'b0;
      s2_q <= 1'b0;
      s3_q <= 1'b0;
      out_q <= 1'b0;
    end else begin
      s1_q <= din;
      s2_q <= s1_q;
      s3_q <= s2_q;
      if (s2_q == s3_q) out_q <= s3_q;
    end
  end
  assign dout = out_q;
endmodule : wif_sync

// file: hdl/wif_ahb_slave.sv
// AHB-Lite slave that decodes the three register words and returns read data.
`timescale 1ns/1ps
`include "wif_defines.svh"
module wif_ahb_slave (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  input wire logic [7:0] rdFlags,
  input wire logic [7:0] rdLevels,
  input wire logic [7:0] rdEnable,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  wif_reg_if.slave regs
);
  logic wrPend_q;
  wif_pkg::wif_reg_e sel_q;
  logic [31:0] rdata_q;
  wire addrPhase = hsel && htrans[1] && hready;
  wire [15:0] addrLow = haddr[15:0];
  wif_pkg::wif_reg_e decSel;
  wire [7:0] rdMux;
  // =====================================================
  // Address decode and read selection
  // =====================================================
  // Unmapped words decode to none; they read zero and ignore writes.
  assign decSel = (haddr[31:16] != 16'h0000) ? wif_pkg::WIF_REG_NONE :
                  (addrLow == `WIF_ADDR_FLAGS) ? wif_pkg::WIF_REG_FLAGS :
                  (addrLow == `WIF_ADDR_LEVELS) ? wif_pkg::WIF_REG_LEVELS :
                  (addrLow == `WIF_ADDR_ENABLE) ? wif_pkg::WIF_REG_ENABLE :
                  wif_pkg::WIF_REG_NONE;
  assign rdMux = (decSel == wif_pkg::WIF_REG_FLAGS) ? rdFlags :
                 (decSel == wif_pkg::WIF_REG_LEVELS) ? rdLevels :
                 (decSel == wif_pkg::WIF_REG_ENABLE) ? rdEnable : 8'h00;
  // Capture the address phase; read data is latched for the data phase.
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) begin
      wrPend_q <= 1'b0;
      sel_q <= wif_pkg::WIF_REG_NONE;
      rdata_q <= 32'h0000_0000;
    end else begin
      wrPend_q <= addrPhase && hwrite;
      if (addrPhase) sel_q <= decSel;
      if (addrPhase && !hwrite) rdata_q <= {24'h00_0000, rdMux};
    end
  end
  // Zero wait states, always OKAY.
  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = rdata_q;
  assign regs.wrEn = wrPend_q;
  assign regs.wrSel = sel_q;
  assign regs.wrData = hwdata[7:0];
endmodule : wif_ahb_slave

// file: bench/wif_fw_model.sv
// Firmware side model: an AHB-Lite master that reads and writes the flag registers.
`timescale 1ns/1ps
module wif_fw_model (
  input wire logic clock,
  input wire logic hreadyout,
  input wire logic [31:0] hrdata,
  output logic hsel,
  output logic [31:0] haddr,
  output logic [1:0] htrans,
  output logic hwrite,
  output logic [2:0] hsize,
  output logic [31:0] hwdata
);
  // The bus idles with no transfer until a task starts one.
  initial begin
    {hsel, haddr, htrans, hwrite, hwdata} = '0;
    hsize = 3'h2;
  end
  // One single word transfer; read data is taken at the edge closing the data phase.
  task automatic xfer(input logic w, input logic [31:0] a, input logic [7:0] d,
    output logic [7:0] q);
    @(posedge clock);
    hsel <= 1'b1;
    htrans <= 2'h2;
    haddr <= a;
    hwrite <= w;
    hwdata <= ~hwdata;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= {24'h0, d};
    do @(posedge clock); while (hreadyout !== 1'b1);
    q = hrdata[7:0];
  endtask : xfer
endmodule : wif_fw_model

// file: bench/wif_top_sva.sv
// Port-level checks of the wake and interrupt flag block.
`timescale 1ns/1ps
module wif_top_sva (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hreadyout,
  input wire logic hresp,
  input wire logic [31:0] hrdata,
  input wire logic clockLockGood,
  input wire logic wakeByButton,
  input wire logic autowakeExpired,
  input wire logic power_event_interrupt,
  input wire logic watchdogNearOverflow,
  input wire logic serialPortIrq,
  input wire logic watchdogIrq,
  input wire logic serialIrq
);
  default clocking cb @(posedge clock);
  endclocking
  default disable iff (!rst_n);
  // Counts calm cycles since the lock input last moved.
  logic [3:0] calm_q;
  always_ff @(posedge clock or negedge rst_n) begin
    if (!rst_n) calm_q <= 4'h0;
    else if ($changed(clockLockGood)) calm_q <= 4'h0;
    else if (calm_q != 4'hF) calm_q <= calm_q + 4'h1;
  end
  // ====
  // Bus, power event and interrupt gate checks.
  zero_wait_a: assert property (hreadyout && !hresp)
    else $error("bus answer not ready with OKAY");
  upper_zero_a: assert property (hrdata[31:8] == 24'h0)
    else $error("read data above low byte");
  pe_pulse_a: assert property (power_event_interrupt |=> !power_event_interrupt)
    else $error("power event longer than one cycle");
  pe_rise_a: assert property ($rose(clockLockGood) |-> ##[1:8] power_event_interrupt)
    else $error("no power event after lock rise");
  // A lock fall counts as a power loss only when no wake source is active.
  pe_fall_a: assert property (($fell(clockLockGood) && !wakeByButton && !autowakeExpired)
    |-> ##[1:8] power_event_interrupt)
    else $error("no power event after lock fall");
  pe_masked_a: assert property (($fell(clockLockGood) && (wakeByButton || autowakeExpired))
    |=> !power_event_interrupt [*8])
    else $error("power event on wake into brownout");
  pe_quiet_a: assert property (calm_q > 4'h9 |-> !power_event_interrupt)
    else $error("power event without lock edge");
  wd_gate_a: assert property (watchdogIrq |-> $past(watchdogNearOverflow))
    else $error("watchdog interrupt without source");
  spi_gate_a: assert property (serialIrq |-> $past(serialPortIrq))
    else $error("serial interrupt without source");
  cover property (power_event_interrupt);
  cover property (watchdogIrq);
  cover property (serialIrq);
endmodule : wif_top_sva
bind wif_top wif_top_sva chk (.clock, .rst_n, .hreadyout, .hresp, .hrdata, .clockLockGood,
  .wakeByButton, .autowakeExpired, .power_event_interrupt, .watchdogNearOverflow,
  .serialPortIrq, .watchdogIrq, .serialIrq);

// file: bench/wif_top_tb.sv
// Self-checking bench for the wake and interrupt flag block.
`timescale 1ns/1ps
`include "wif_defines.svh"
module wif_top_tb;
  logic clock, rst_n, hsel, hwrite, hreadyout, hresp, push_button, clockLockGood;
  logic wakeByButton, autowakeExpired, ce_transfer_busy, one_second_pulse, collisionEventA;
  logic collisionEventB, lowPowerRequest, watchdogNearOverflow, serialPortIrq;
  logic power_event_interrupt, watchdogIrq, serialIrq;
  logic [31:0] haddr, hwdata, hrdata;
  logic [1:0] htrans;
  logic [2:0] hsize;
  logic [6:0] extIrqIn;
  wif_pkg::wif_byte_t got;
  int badCount = 0;
  int totalChecks = 0;
  int cycleCount = 0;
  localparam logic [31:0] aFl = {16'h0000, `WIF_ADDR_FLAGS};
  localparam logic [31:0] aLv = {16'h0000, `WIF_ADDR_LEVELS};
  localparam logic [31:0] aEn = {16'h0000, `WIF_ADDR_ENABLE};
  wif_top dut (.clock, .rst_n, .hsel, .haddr, .htrans, .hwrite, .hsize, .hwdata,
    .hready(hreadyout), .hreadyout, .hresp, .hrdata, .push_button, .clockLockGood,
    .wakeByButton, .autowakeExpired, .ce_transfer_busy, .one_second_pulse,
    .collisionEventA, .collisionEventB, .lowPowerRequest, .extIrqIn, .watchdogNearOverflow,
    .serialPortIrq, .power_event_interrupt, .watchdogIrq, .serialIrq);
  wif_fw_model fw (.clock, .hreadyout, .hrdata, .hsel, .haddr, .htrans, .hwrite, .hsize,
    .hwdata);
  // The clock toggles every 2.5 ns, a period of 5 ns.
  initial begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  // A hang ends the run as a mismatch.
  always @(posedge clock) begin
    cycleCount++;
    if (cycleCount == 5000) begin
      badCount++;
      wrap_up();
    end
  end
  // ====
  // Compare, bus and closing tasks.
  task automatic chk(input wif_pkg::wif_byte_t g, input wif_pkg::wif_byte_t e);
    totalChecks++;
    if (g !== e) begin
      badCount++;
      $display("mismatch at %0t: got %h expected %h", $time, g, e);
    end
  endtask : chk
  task automatic rd(input logic [31:0] a, input wif_pkg::wif_byte_t e);
    fw.xfer(1'b0, a, 8'h00, got);
    chk(got, e);
  endtask : rd
  task automatic wr(input logic [31:0] a, input wif_pkg::wif_byte_t d);
    fw.xfer(1'b1, a, d, got);
  endtask : wr
  task automatic wrap_up;
    $display("checks %0d mismatches %0d", totalChecks, badCount);
    if (badCount == 0 && totalChecks > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : wrap_up
  // ====
  // Test sequence.
  initial begin
    {rst_n, push_button, clockLockGood, wakeByButton, autowakeExpired, ce_transfer_busy} = '0;
    {one_second_pulse, collisionEventA, collisionEventB, lowPowerRequest, extIrqIn} = '0;
    {watchdogNearOverflow, serialPortIrq} = '0;
    repeat (20) @(posedge clock);
    rst_n <= 1'b1;
    rd(aFl, `WIF_RST_BYTE);
    rd(aEn, 8'h00);
    rd(32'h0000_0100, 8'h00);
    $display("test reset done");
    push_button <= 1'b1;
    repeat (8) @(posedge clock);
    rd(aFl, 8'h10);
    wr(aFl, 8'hF0);
    rd(aFl, 8'h10);
    push_button <= 1'b0;
    repeat (8) @(posedge clock);
    rd(aFl, 8'h10);
    wr(aFl, 8'h00);
    rd(aFl, 8'h00);
    push_button <= 1'b1;
    repeat (8) @(posedge clock);
    lowPowerRequest <= 1'b1;
    @(posedge clock);
    lowPowerRequest <= 1'b0;
    push_button <= 1'b0;
    rd(aFl, 8'h00);
    $display("test button done");
    for (int i = 0; i < 3; i++) begin
      wakeByButton <= (i == 1);
      autowakeExpired <= (i == 2);
      clockLockGood <= 1'b1;
      repeat (10) @(posedge clock);
      clockLockGood <= 1'b0;
      repeat (10) @(posedge clock);
      {wakeByButton, autowakeExpired} <= 2'b00;
      rd(aFl, (i == 0) ? 8'hC0 : (i == 1) ? 8'h40 : 8'h60);
      wr(aFl, 8'h00);
      rd(aFl, 8'h00);
    end
    $display("test power done");
    for (int v = 1; v < 4; v++) begin
      {one_second_pulse, ce_transfer_busy} <= v[1:0];
      repeat (8) @(posedge clock);
      rd(aFl, {6'h00, v[1:0]});
    end
    {one_second_pulse, ce_transfer_busy} <= 2'b00;
    repeat (8) @(posedge clock);
    rd(aFl, 8'h00);
    {collisionEventB, collisionEventA} <= 2'b01;
    @(posedge clock);
    {collisionEventB, collisionEventA} <= 2'b10;
    @(posedge clock);
    {collisionEventB, collisionEventA} <= 2'b00;
    rd(aFl, 8'h0C);
    wr(aFl, 8'h04);
    rd(aFl, 8'h04);
    wr(aFl, 8'h00);
    rd(aFl, 8'h00);
    wr(aFl, 8'h08);
    rd(aFl, 8'h08);
    wr(aFl, 8'h00);
    $display("test flags done");
    for (int k = 0; k < 3; k++) begin
      extIrqIn <= (k == 0) ? 7'h55 : (k == 1) ? 7'h2A : 7'h00;
      repeat (8) @(posedge clock);
      rd(aLv, (k == 0) ? 8'h55 : (k == 1) ? 8'h2A : 8'h00);
    end
    {watchdogNearOverflow, serialPortIrq} <= 2'b11;
    for (int j = 0; j < 4; j++) begin
      wr(aEn, {3'h0, j[1], 3'h0, j[0]});
      rd(aEn, {3'h0, j[1], 3'h0, j[0]});
      chk({3'h0, serialIrq, 3'h0, watchdogIrq}, {3'h0, j[1], 3'h0, j[0]});
    end
    {watchdogNearOverflow, serialPortIrq} <= 2'b00;
    repeat (3) @(posedge clock);
    chk({3'h0, serialIrq, 3'h0, watchdogIrq}, 8'h00);
    $display("test levels done");
    wrap_up();
  end
endmodule : wif_top_tb
